// ### verilog/als_pkg.sv
// package for the per-channel line status and transmit fifo block
// assumes a 125 MHz system clock and a plain strobe register port
package als_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [3:0] ADDR_LINE_PARAM  = 4'h0;
    localparam logic [3:0] ADDR_LINE_STATUS = 4'h4;
    localparam logic [3:0] ADDR_FREE_SPACE  = 4'h8;
    localparam logic [3:0] ADDR_TX_PORT     = 4'hC;
    localparam logic [3:0] ADDR_MODE_CTRL   = 4'h2;
    // field positions
    localparam int TX_SPEED_LSB   = 12;
    localparam int RX_SPEED_LSB   = 8;
    localparam int ST_DSR_BIT     = 15;
    localparam int ST_RI_BIT      = 13;
    localparam int ST_DCD_BIT     = 12;
    localparam int ST_CTS_BIT     = 11;
    localparam int ST_CAP_BIT     = 9;
    localparam int ST_MODE_BIT    = 8;
    // reset values and codes
    localparam logic [3:0]  SPEED_RESET     = 4'hD;
    localparam logic [7:0]  FREE_RESET      = 8'h40;
    localparam logic [7:0]  FLOW_RESUME     = 8'h11;
    localparam logic [7:0]  FLOW_STOP       = 8'h13;
    localparam logic [2:0]  RECEIVE_BUFFER_ENTRY_MODEM_TAG  = 3'h7;
    localparam logic [15:0] LINE_PARAM_RESET = 16'hDD18;
    localparam int          CLK_HZ          = 125000000;
    // bit rate times ten for each speed code
    function automatic logic [19:0] als_rate_x10(input logic [3:0] code);
        case (code)
            4'h0: als_rate_x10 = 20'h001F4;
            4'h1: als_rate_x10 = 20'h002EE;
            4'h2: als_rate_x10 = 20'h0044C;
            4'h3: als_rate_x10 = 20'h00542;
            4'h4: als_rate_x10 = 20'h005DC;
            4'h5: als_rate_x10 = 20'h00BB8;
            4'h6: als_rate_x10 = 20'h01770;
            4'h7: als_rate_x10 = 20'h02EE0;
            4'h8: als_rate_x10 = 20'h04650;
            4'h9: als_rate_x10 = 20'h04E20;
            4'hA: als_rate_x10 = 20'h05DC0;
            4'hB: als_rate_x10 = 20'h0BB80;
            4'hC: als_rate_x10 = 20'h11940;
            4'hD: als_rate_x10 = 20'h17700;
            4'hE: als_rate_x10 = 20'h2EE00;
            default: als_rate_x10 = 20'h5DC00;
        endcase
    endfunction
    // clock cycles per bit for a speed code
    function automatic logic [23:0] als_bit_cycles(input logic [3:0] code);
        als_bit_cycles = 24'((64'(CLK_HZ) * 64'd10) / 64'(als_rate_x10(code)));
    endfunction
endpackage

// ### verilog/als_fifo_if.sv
`timescale 1ns/1ps
// carrier between the top and the transmit fifo
// assumes one clock domain
interface als_fifo_if;
    logic       push;
    logic [7:0] push_data;
    logic       pop;
    logic [7:0] pop_data;
    logic       empty;
    logic [6:0] free;
    modport fifo (input push, push_data, pop, output pop_data, empty, free);
    modport user (output push, push_data, pop, input pop_data, empty, free);
endinterface

// ### verilog/als_tx_fifo.sv
`timescale 1ns/1ps
// transmit character fifo with free-space count
// assumes the user never pushes when free is zero or pops when empty
module als_tx_fifo
    import als_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // fifo side
    als_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);
    logic [7:0]  mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [6:0]  free_q, free_d;
    logic [7:0]  out_q, out_d;

    // pointer and count next values
    always_comb begin
        wr_d   = wr_q;
        rd_d   = rd_q;
        free_d = free_q;
        out_d  = out_q;
        if (f.push) begin
            wr_d = AW'(wr_q + 1'b1);
        end
        if (f.pop) begin
            rd_d  = AW'(rd_q + 1'b1);
            out_d = mem[rd_q];
        end
        if (f.push && !f.pop) begin
            free_d = 7'(free_q - 7'd1);
        end else if (f.pop && !f.push) begin
            free_d = 7'(free_q + 7'd1);
        end
    end

    // registers; storage written only on push
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q   <= '0;
            rd_q   <= '0;
            free_q <= 7'(FREE_RESET);
            out_q  <= 8'h00;
        end else if (ce) begin
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            free_q <= free_d;
            out_q  <= out_d;
            if (f.push) begin
                mem[wr_q] <= f.push_data;
            end
        end
    end

    assign f.free     = free_q;
    assign f.empty    = (free_q == 7'(DEPTH));
    assign f.pop_data = out_q;
endmodule

// ### verilog/als_line_status.sv
`timescale 1ns/1ps
// per-channel line status, speed codes and transmit fifo write port
// assumes synchronous modem inputs and a host that never waits
//
// Functional notes
// - only octal 21 resume, 23 stop
// - speed code maps 16 fixed bit rates
// - tx speed bits 15:12, reset 1101
// - rx speed bits 11:8, reset 1101
// - status high byte modem, low undefined
// - bit 15 live data-set-ready
// - bit 13 live ring indicator
// - bit 12 live carrier detect
// - bit 11 live clear-to-send
// - modem change queues entry tagged 111
// - bit 9 always reads zero
// - bit 8 shows programming mode
// - fifo registers only in extended mode
// - free-space low byte, 0 to 64
// - reset sets free space 64
// - word write queues low then high
// - lsbs at bits 0 and 8
// - byte write queues one low character
module als_line_status
    import als_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_byte,
    output logic      [15:0] reg_rdata,
    // modem inputs
    input  wire logic        modem_dsr,
    input  wire logic        modem_ri,
    input  wire logic        modem_dcd,
    input  wire logic        modem_cts,
    // received characters
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_char,
    // receive buffer entries
    output logic             receive_buffer_entry_valid,
    output logic      [15:0] receive_buffer_entry,
    // transmit serial line
    output logic             tx_line,
    output logic             tx_busy,
    output logic             flow_stopped
);
    typedef enum {TX_IDLE, TX_LOAD, TX_SHIFT} als_tx_state_t;

    als_fifo_if fi ();

    logic [15:0] lpr_q, lpr_d;
    logic        mode_q, mode_d;
    logic [15:0] rdata_q, rdata_d;
    logic [3:0]  modem_q;
    logic [3:0]  modem_now;
    logic        rbv_q, rbv_d;
    logic [15:0] rbe_q, rbe_d;
    logic        stop_q, stop_d;
    logic        hi_pend_q, hi_pend_d;
    logic [7:0]  hi_char_q, hi_char_d;
    als_tx_state_t st_q, st_d;
    logic [9:0]  sh_q, sh_d;
    logic [3:0]  nb_q, nb_d;
    logic [23:0] bc_q, bc_d;
    logic        wr_port, wr_lpr, wr_mode;
    logic        push, pop;
    logic [7:0]  push_data;
    logic [15:0] status;

    als_tx_fifo #(.DEPTH(DEPTH)) u_fifo (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .f     (fi.fifo)
    );

    // live status word
    always_comb begin
        status              = 16'h0000;
        status[ST_DSR_BIT]  = modem_dsr;
        status[ST_RI_BIT]   = modem_ri;
        status[ST_DCD_BIT]  = modem_dcd;
        status[ST_CTS_BIT]  = modem_cts;
        status[ST_CAP_BIT]  = 1'b0;
        status[ST_MODE_BIT] = mode_q;
    end
    assign modem_now = {modem_dsr, modem_ri, modem_dcd, modem_cts};

    // write decode
    assign wr_lpr  = reg_wr && (reg_addr == ADDR_LINE_PARAM);
    assign wr_mode = reg_wr && (reg_addr == ADDR_MODE_CTRL);
    assign wr_port = reg_wr && (reg_addr == ADDR_TX_PORT) && mode_q;

    // fifo push: low byte first, high byte next cycle
    always_comb begin
        push      = 1'b0;
        push_data = 8'h00;
        hi_pend_d = 1'b0;
        hi_char_d = hi_char_q;
        if (hi_pend_q) begin
            push      = (fi.free != 7'd0);
            push_data = hi_char_q;
        end else if (wr_port) begin
            push      = (fi.free != 7'd0);
            push_data = reg_wdata[7:0];
            if (!reg_byte) begin
                hi_pend_d = 1'b1;
                hi_char_d = reg_wdata[15:8];
            end
        end
    end
    assign fi.push      = push;
    assign fi.push_data = push_data;
    assign fi.pop       = pop;

    // register and read path
    always_comb begin
        lpr_d   = lpr_q;
        mode_d  = mode_q;
        rdata_d = 16'h0000;
        if (wr_lpr) begin
            lpr_d = reg_wdata;
        end
        if (wr_mode) begin
            mode_d = reg_wdata[0];
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_LINE_PARAM:  rdata_d = lpr_q;
                ADDR_MODE_CTRL:   rdata_d = {15'h0000, mode_q};
                ADDR_LINE_STATUS: rdata_d = status;
                ADDR_FREE_SPACE:  rdata_d = mode_q ? {9'h000, fi.free} : 16'h0000;
                default:          rdata_d = 16'h0000;
            endcase
        end
    end

    // modem change reports and flow control from received characters
    always_comb begin
        rbv_d  = 1'b0;
        rbe_d  = rbe_q;
        stop_d = stop_q;
        if (modem_now != modem_q) begin
            rbv_d = 1'b1;
            rbe_d = {1'b0, RECEIVE_BUFFER_ENTRY_MODEM_TAG, 4'h0, status[15:8]};
        end else if (rx_valid) begin
            rbv_d = 1'b1;
            rbe_d = {8'h00, rx_char};
        end
        if (rx_valid && rx_char == FLOW_STOP) begin
            stop_d = 1'b1;
        end else if (rx_valid && rx_char == FLOW_RESUME) begin
            stop_d = 1'b0;
        end
    end

    // transmitter: 8N1 at the transmit speed code
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        nb_d = nb_q;
        bc_d = bc_q;
        pop  = 1'b0;
        case (st_q)
            TX_IDLE: begin
                if (!fi.empty && !stop_q) begin
                    pop  = 1'b1;
                    st_d = TX_LOAD;
                end
            end
            TX_LOAD: begin
                sh_d = {1'b1, fi.pop_data, 1'b0};
                nb_d = 4'd10;
                bc_d = als_bit_cycles(lpr_q[TX_SPEED_LSB +: 4]);
                st_d = TX_SHIFT;
            end
            TX_SHIFT: begin
                if (bc_q <= 24'd1) begin
                    bc_d = als_bit_cycles(lpr_q[TX_SPEED_LSB +: 4]);
                    sh_d = {1'b1, sh_q[9:1]};
                    nb_d = 4'(nb_q - 4'd1);
                    if (nb_q == 4'd1) begin
                        st_d = TX_IDLE;
                    end
                end else begin
                    bc_d = 24'(bc_q - 24'd1);
                end
            end
            default: st_d = TX_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lpr_q     <= LINE_PARAM_RESET;
            mode_q    <= 1'b0;
            rdata_q   <= 16'h0000;
            modem_q   <= 4'h0;
            rbv_q     <= 1'b0;
            rbe_q     <= 16'h0000;
            stop_q    <= 1'b0;
            hi_pend_q <= 1'b0;
            hi_char_q <= 8'h00;
            st_q      <= TX_IDLE;
            sh_q      <= 10'h3FF;
            nb_q      <= 4'h0;
            bc_q      <= 24'h000000;
        end else if (ce) begin
            lpr_q     <= lpr_d;
            mode_q    <= mode_d;
            rdata_q   <= rdata_d;
            modem_q   <= modem_now;
            rbv_q     <= rbv_d;
            rbe_q     <= rbe_d;
            stop_q    <= stop_d;
            hi_pend_q <= hi_pend_d;
            hi_char_q <= hi_char_d;
            st_q      <= st_d;
            sh_q      <= sh_d;
            nb_q      <= nb_d;
            bc_q      <= bc_d;
        end
    end

    assign reg_rdata            = rdata_q;
    assign receive_buffer_entry_valid           = rbv_q;
    assign receive_buffer_entry = rbe_q;
    assign tx_line              = (st_q == TX_SHIFT) ? sh_q[0] : 1'b1;
    assign tx_busy              = (st_q != TX_IDLE);
    assign flow_stopped         = stop_q;
endmodule

// ### verification/als_props.sv
// assertions on the line status block ports
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module als_props
    import als_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // modem and receive side
    input wire logic        modem_dsr,
    input wire logic        modem_ri,
    input wire logic        modem_dcd,
    input wire logic        modem_cts,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_char,
    input wire logic        receive_buffer_entry_valid,
    input wire logic [15:0] receive_buffer_entry,
    input wire logic        flow_stopped
);
    logic mode_q;
    logic mode_d;
    logic st_rd;
    logic fr_rd;
    logic flow_rx;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // programming mode as last written
    assign mode_d = (ce && reg_wr && reg_addr == ADDR_MODE_CTRL) ? reg_wdata[0] : mode_q;
    always_ff @(posedge clk) begin
        mode_q <= rst_b ? mode_d : 1'b0;
    end
    // read requests and flow codes
    assign st_rd   = ce && reg_rd && reg_addr == ADDR_LINE_STATUS;
    assign fr_rd   = ce && reg_rd && reg_addr == ADDR_FREE_SPACE;
    assign flow_rx = ce && rx_valid && (rx_char == FLOW_STOP || rx_char == FLOW_RESUME);
    live_modem_a: assert property (
        st_rd |=> reg_rdata[15] == $past(modem_dsr) && reg_rdata[13] == $past(modem_ri)
            && reg_rdata[12] == $past(modem_dcd) && reg_rdata[11] == $past(modem_cts))
        else $error("live modem bits wrong");
    cap_zero_a: assert property (st_rd |=> !reg_rdata[9])
        else $error("capability bit not zero");
    mode_bit_a: assert property (st_rd |=> reg_rdata[8] == $past(mode_q))
        else $error("mode bit wrong");
    free_gate_a: assert property (
        fr_rd |=> ($past(mode_q) ? reg_rdata <= 16'(DEPTH) : reg_rdata == 16'h0000))
        else $error("free space read wrong");
    modem_entry_a: assert property (
        ce && $past(rst_b) && (modem_dsr != $past(modem_dsr) || modem_ri != $past(modem_ri)
            || modem_dcd != $past(modem_dcd) || modem_cts != $past(modem_cts))
        |=> receive_buffer_entry_valid && receive_buffer_entry[14:12] == 3'h7 && receive_buffer_entry[7] == $past(modem_dsr)
            && receive_buffer_entry[5:3] == {$past(modem_ri), $past(modem_dcd), $past(modem_cts)})
        else $error("modem entry wrong");
    stop_code_a: assert property (ce && rx_valid && rx_char == FLOW_STOP |=> flow_stopped)
        else $error("stop code ignored");
    resume_code_a: assert property (ce && rx_valid && rx_char == FLOW_RESUME |=> !flow_stopped)
        else $error("resume code ignored");
    other_code_a: assert property (!flow_rx |=> $stable(flow_stopped))
        else $error("flow state moved");
    // main scenarios reached
    cover property (receive_buffer_entry_valid && receive_buffer_entry[14:12] == 3'h7);
    cover property (fr_rd && mode_q);
    cover property ($rose(flow_stopped));
endmodule

// ### verification/als_modem_model.sv
// modem and terminal model on the serial side
// assumes tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module als_modem_model #(
    parameter int BIT_CYC = 3255
) (
    // clock and transmit line
    input  wire logic       clk,
    input  wire logic       tx_line,
    // modem levels and received characters
    output logic            modem_dsr,
    output logic            modem_ri,
    output logic            modem_dcd,
    output logic            modem_cts,
    output logic            rx_valid,
    output logic      [7:0] rx_char
);
    // quiet lines at start
    initial begin
        {modem_dsr, modem_ri, modem_dcd, modem_cts} = 4'h0;
        rx_valid = 1'b0;
        rx_char  = 8'h00;
    end
    // all four modem levels at once
    task automatic set_lines(input logic [3:0] m);
        {modem_dsr, modem_ri, modem_dcd, modem_cts} <= m;
    endtask
    // one received character, data scrambled after
    task automatic send_char(input logic [7:0] c);
        rx_valid <= 1'b1;
        rx_char  <= c;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_char  <= ~c;
    endtask
    // mid-bit sampling of one frame, lsb first
    task automatic recv_char(output logic [7:0] c, output bit ok);
        int n;
        n = 0;
        while (tx_line !== 1'b1 && n < BIT_CYC) begin
            @(posedge clk);
            n++;
        end
        while (tx_line !== 1'b0 && n < 12 * BIT_CYC) begin
            @(posedge clk);
            n++;
        end
        ok = (tx_line === 1'b0);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            c[i] = tx_line;
        end
    endtask
endmodule

// ### verification/als_line_status_tb_top.sv
// self-checking bench for the line status block
// assumes the package, checker and modem model are compiled first
`timescale 1ns/1ps
module als_line_status_tb_top;
    import als_pkg::*;
    localparam int BIT_CYC = CLK_HZ / 38400;
    typedef struct packed {logic [3:0] addr; logic [3:0] mdm; logic [15:0] exp;} als_row_t;
    logic        clk, rst_b, ce, reg_wr, reg_rd, reg_byte, rx_valid, receive_buffer_entry_valid;
    logic        modem_dsr, modem_ri, modem_dcd, modem_cts, tx_line, flow_stopped;
    logic [3:0]  reg_addr;
    logic [7:0]  rx_char;
    logic [15:0] reg_wdata, reg_rdata, receive_buffer_entry;
    int          fails, num_checks;
    als_row_t    rows [7] = '{
        '{ADDR_LINE_PARAM, 4'h0, 16'hDD18},
        '{ADDR_FREE_SPACE, 4'h0, 16'h0000},
        '{4'h6, 4'h0, 16'h0000},
        '{ADDR_LINE_STATUS, 4'h8, 16'h8000},
        '{ADDR_LINE_STATUS, 4'h4, 16'h2000},
        '{ADDR_LINE_STATUS, 4'h2, 16'h1000},
        '{ADDR_LINE_STATUS, 4'h1, 16'h0800}
    };
    als_line_status dut_u (.clk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_byte,
        .reg_rdata, .modem_dsr, .modem_ri, .modem_dcd, .modem_cts, .rx_valid, .rx_char,
        .receive_buffer_entry_valid, .receive_buffer_entry, .tx_line, .tx_busy(), .flow_stopped);
    als_modem_model #(.BIT_CYC(BIT_CYC)) m_u (.clk, .tx_line, .modem_dsr, .modem_ri,
        .modem_dcd, .modem_cts, .rx_valid, .rx_char);
    // value comparison
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    // register write, two idle cycles after
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic b);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_byte  <= b;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // register read compared in the answer cycle
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string what);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, e, reg_rdata);
        @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        complete_run();
    end
    initial begin
        logic [7:0] c;
        bit         ok;
        {rst_b, reg_wr, reg_rd, reg_byte, reg_addr, reg_wdata} = '0;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // plain reads from the table
        foreach (rows[i]) begin
            m_u.set_lines(rows[i].mdm);
            repeat (2) @(posedge clk);
            rd_chk(rows[i].addr, rows[i].exp, "table read");
        end
        m_u.set_lines(4'h0);
        wr(ADDR_MODE_CTRL, 16'h0001, 1'b0);
        rd_chk(ADDR_LINE_STATUS, 16'h0100, "mode bit");
        rd_chk(ADDR_FREE_SPACE, 16'h0040, "free reset");
        // hold transmit while the fifo fills
        m_u.send_char(FLOW_STOP);
        m_u.send_char(8'h12);
        wr(ADDR_LINE_PARAM, 16'hFF18, 1'b0);
        rd_chk(ADDR_LINE_PARAM, 16'hFF18, "speed code");
        chk("flow held", 16'h0001, 16'(flow_stopped));
        wr(ADDR_TX_PORT, 16'h4241, 1'b0);
        wr(ADDR_TX_PORT, 16'h55C3, 1'b1);
        rd_chk(ADDR_FREE_SPACE, 16'h003D, "word then byte");
        for (int i = 0; i < 31; i++) wr(ADDR_TX_PORT, 16'h3030, 1'b0);
        rd_chk(ADDR_FREE_SPACE, 16'h0000, "full");
        wr(ADDR_TX_PORT, 16'h0031, 1'b1);
        rd_chk(ADDR_FREE_SPACE, 16'h0000, "write when full");
        // release and watch the line at 38400
        m_u.send_char(FLOW_RESUME);
        m_u.recv_char(c, ok);
        chk("first char", 16'h0141, {7'h00, ok, c});
        rd_chk(ADDR_FREE_SPACE, 16'h0001, "one removed");
        m_u.recv_char(c, ok);
        chk("second char", 16'h0142, {7'h00, ok, c});
        // reset in mid-run
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_chk(ADDR_LINE_PARAM, 16'hDD18, "param after reset");
        wr(ADDR_MODE_CTRL, 16'h0001, 1'b0);
        rd_chk(ADDR_FREE_SPACE, 16'h0040, "free after reset");
        complete_run();
    end
endmodule
bind als_line_status als_props #(.DEPTH(DEPTH)) props_u (.clk, .rst_b, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .modem_dsr, .modem_ri, .modem_dcd, .modem_cts, .rx_valid,
    .rx_char, .receive_buffer_entry_valid, .receive_buffer_entry, .flow_stopped);
